// ===== adcc_pkg.sv
// Constants and types for the converter serial and conversion control.
// Assumes a 25 MHz system clock and a host-driven serial clock.
`default_nettype none
package adcc_pkg;
    localparam int CLK_HZ      = 25_000_000;
    localparam int TIMEOUT_MS  = 28;
    // Idle-low serial clock limit, whole cycles
    localparam int TIMEOUT_CYC = CLK_HZ / 1000 * TIMEOUT_MS;
    localparam int FRAME_BITS  = 16;
    localparam int CONV_CNT_W  = 22;
    localparam int BUF_DEPTH   = 2;
    // Samples per second for each data-rate code
    localparam int SPS_TABLE [8] = '{8, 16, 32, 64, 128, 250, 475, 860};
    localparam logic [15:0] CFG_RST   = 16'h058b;
    localparam logic [1:0]  WRITE_KEY = 2'h1;

    typedef struct packed {
        logic       start;
        logic [2:0] input_select_field;
        logic [2:0] gain;
        logic       single;
        logic [2:0] rate;
        logic [1:0] spare_hi;
        logic [1:0] write_key;
        logic       spare_lo;
    } adcc_cfg_type;

    typedef enum logic [1:0] {
        ADCC_NEG_IN1,
        ADCC_NEG_IN3,
        ADCC_NEG_GND
    } adcc_neg_type;

    typedef struct packed {
        logic [1:0]   pos;
        adcc_neg_type neg;
    } adcc_route_type;

    typedef enum logic [0:0] {
        ADCC_PD,
        ADCC_CONV
    } adcc_state_type;
endpackage
`default_nettype wire

// ===== adcc_ctrl.sv
// Serial port, idle timeout, conversion sequencing and input routing.
// Assumes the filter delivers results on i_sys_clk and the host drives
// the serial clock; that clock stands still outside frames.
// Operation
// RULE_01: Chip select is active low; serial logic only works while it is low.
// RULE_02: One output pin carries read data and an active-low ready flag.
// RULE_03: Input data is sampled on each falling serial clock edge.
// RULE_04: Each new output bit is shifted out after a rising edge.
// RULE_05: Output pin is driven only while chip select is low.
// RULE_06: Serial clock low beyond the timeout resets the serial port.
// RULE_07: Single-shot mode makes one conversion per request, storing result.
// RULE_08: After a single-shot conversion the converter powers down.
// RULE_09: Continuous mode restarts a conversion as soon as one ends.
// RULE_10: Continuous conversions complete at the programmed data rate.
// RULE_11: A read returns the most recently completed conversion.
// RULE_12: Input selection is the three-bit field at bits 14 to 12.
// RULE_13: Selector offers four single-ended, one pair, three against input 3.
// RULE_14: Single-ended selections tie the negative converter input to ground.
// RULE_15: Pairs are inputs 0/1 and 2/3, positive first.
// RULE_16: Idle with chip select low, output shows low while a result waits.
`timescale 1ns/1ps
`default_nettype none
module adcc_ctrl #(
    parameter int CONV_CLK_HZ = adcc_pkg::CLK_HZ,
    parameter int TIMEOUT_CYC = adcc_pkg::TIMEOUT_CYC,
    parameter int DEPTH       = adcc_pkg::BUF_DEPTH
) (
    input  wire logic                     i_sys_clk,
    input  wire logic                     i_arst_n,
    input  wire logic                     i_clk_en,
    input  wire logic                     i_sclk,
    input  wire logic                     i_cs_n,
    input  wire logic                     i_din,
    output logic                          o_dout,
    output logic                          o_dout_oe_n,
    output logic                          o_conv_end,
    output logic                          o_power_down,
    output adcc_pkg::adcc_route_type      o_route,
    output logic [2:0]                    o_gain,
    input  wire logic                     i_res_valid,
    input  wire logic [15:0]              i_res_data,
    output logic                          o_res_ready
);
    localparam int TO_W  = $clog2(TIMEOUT_CYC + 1);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam int BIT_W = $clog2(adcc_pkg::FRAME_BITS + 2);
    localparam int IN_W  = $clog2(adcc_pkg::FRAME_BITS);

    typedef logic [adcc_pkg::CONV_CNT_W-1:0] adcc_tmr_type;
    typedef logic [TO_W-1:0]                 adcc_to_type;
    typedef logic [PTR_W-1:0]                adcc_ptr_type;
    typedef logic [CNT_W-1:0]                adcc_cnt_type;
    typedef logic [BIT_W-1:0]                adcc_bit_type;
    typedef logic [IN_W-1:0]                 adcc_in_type;

    // Timer start value of one conversion period, counted down to zero
    function automatic adcc_tmr_type conv_last(input logic [2:0] rate);
        conv_last = adcc_tmr_type'(CONV_CLK_HZ
                                   / adcc_pkg::SPS_TABLE[rate] - 1);
    endfunction

    function automatic adcc_ptr_type ptr_inc(input adcc_ptr_type p);
        ptr_inc = (p == adcc_ptr_type'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    function automatic adcc_pkg::adcc_route_type sel_route(
        input logic [2:0] sel);
        sel_route.pos = sel[1:0];
        sel_route.neg = adcc_pkg::ADCC_NEG_GND;
        if (!sel[2]) begin
            case (sel[1:0])
                2'h0: begin
                    sel_route.pos = 2'h0;
                    sel_route.neg = adcc_pkg::ADCC_NEG_IN1;
                end
                2'h1: begin
                    sel_route.pos = 2'h0;
                    sel_route.neg = adcc_pkg::ADCC_NEG_IN3;
                end
                2'h2: begin
                    sel_route.pos = 2'h1;
                    sel_route.neg = adcc_pkg::ADCC_NEG_IN3;
                end
                default: begin
                    sel_route.pos = 2'h2;
                    sel_route.neg = adcc_pkg::ADCC_NEG_IN3;
                end
            endcase
        end
    endfunction

    // ---------------- Serial clock domain ----------------
    logic                          timeout_q;
    logic                          spi_rst_n;
    adcc_bit_type                  out_cnt_q;
    adcc_bit_type                  out_cnt_d;
    adcc_in_type                   in_cnt_q;
    adcc_in_type                   in_cnt_d;
    logic [14:0]                   in_sr_q;
    logic [14:0]                   in_sr_d;
    adcc_pkg::adcc_cfg_type        shadow_q;
    adcc_pkg::adcc_cfg_type        shadow_d;
    logic                          wtgl_q;
    logic                          wtgl_d;

    // Frame state dies with chip select or an idle timeout
    assign spi_rst_n = i_arst_n & ~i_cs_n & ~timeout_q; // RULE_01 RULE_06

    always_comb begin
        out_cnt_d = out_cnt_q;
        if (out_cnt_q <= adcc_bit_type'(adcc_pkg::FRAME_BITS)) begin
            out_cnt_d = out_cnt_q + 1'b1; // RULE_04
        end
    end

    always_ff @(posedge i_sclk or negedge spi_rst_n) begin
        if (!spi_rst_n) begin
            out_cnt_q <= '0;
        end else begin
            out_cnt_q <= out_cnt_d;
        end
    end

    always_comb begin
        in_sr_d  = {in_sr_q[13:0], i_din}; // RULE_03
        in_cnt_d = in_cnt_q + 1'b1;
        shadow_d = shadow_q;
        wtgl_d   = wtgl_q;
        if (in_cnt_q == adcc_in_type'(adcc_pkg::FRAME_BITS - 1)) begin
            shadow_d = {in_sr_q, i_din};
            wtgl_d   = ~wtgl_q;
        end
    end

    always_ff @(negedge i_sclk or negedge spi_rst_n) begin
        if (!spi_rst_n) begin
            in_sr_q  <= '0;
            in_cnt_q <= '0;
        end else begin
            in_sr_q  <= in_sr_d;
            in_cnt_q <= in_cnt_d;
        end
    end

    // Word and toggle survive chip select so the crossing stays intact
    always_ff @(negedge i_sclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            shadow_q <= adcc_pkg::CFG_RST;
            wtgl_q   <= 1'b0;
        end else begin
            shadow_q <= shadow_d;
            wtgl_q   <= wtgl_d;
        end
    end

    // ---------------- System clock domain ----------------
    logic cs_m_q;
    logic cs_s_q;
    logic sck_m_q;
    logic sck_s_q;
    logic tgl_m_q;
    logic tgl_s_q;
    logic tgl_p_q;
    logic tgl_edge;

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cs_m_q  <= 1'b1;
            cs_s_q  <= 1'b1;
            sck_m_q <= 1'b0;
            sck_s_q <= 1'b0;
            tgl_m_q <= 1'b0;
            tgl_s_q <= 1'b0;
            tgl_p_q <= 1'b0;
        end else if (i_clk_en) begin
            cs_m_q  <= i_cs_n;
            cs_s_q  <= cs_m_q;
            sck_m_q <= i_sclk;
            sck_s_q <= sck_m_q;
            tgl_m_q <= wtgl_q;
            tgl_s_q <= tgl_m_q;
            tgl_p_q <= tgl_s_q;
        end
    end

    assign tgl_edge = tgl_s_q ^ tgl_p_q;

    // Idle timeout on the synchronised serial clock
    // One pulse per idle spell, so the next frame's first edges count
    adcc_to_type to_cnt_q;
    adcc_to_type to_cnt_d;
    logic        timeout_d;

    always_comb begin
        to_cnt_d  = to_cnt_q;
        timeout_d = 1'b0;
        if (sck_s_q) begin
            to_cnt_d = '0;
        end else if (to_cnt_q != adcc_to_type'(TIMEOUT_CYC)) begin
            to_cnt_d = to_cnt_q + 1'b1;
            if (to_cnt_q == adcc_to_type'(TIMEOUT_CYC - 1)) begin
                timeout_d = 1'b1; // RULE_06
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            to_cnt_q  <= '0;
            timeout_q <= 1'b0;
        end else if (i_clk_en) begin
            to_cnt_q  <= to_cnt_d;
            timeout_q <= timeout_d;
        end
    end

    // Two-entry result buffer; drains only while chip select is high
    logic [15:0]  mem_q [DEPTH];
    adcc_ptr_type wr_q;
    adcc_ptr_type rd_q;
    adcc_cnt_type cnt_q;
    logic         push;
    logic         pop;

    assign o_res_ready = (cnt_q != adcc_cnt_type'(DEPTH));
    assign push        = i_res_valid & o_res_ready;
    assign pop         = (cnt_q != '0) & cs_s_q;

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else if (i_clk_en) begin
            if (push) begin
                wr_q <= ptr_inc(wr_q);
            end
            if (pop) begin
                rd_q <= ptr_inc(rd_q);
            end
            cnt_q <= cnt_q + adcc_cnt_type'(push) - adcc_cnt_type'(pop);
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_clk_en && push) begin
            mem_q[wr_q] <= i_res_data;
        end
    end

    // Configuration, result snapshot and ready flag
    adcc_pkg::adcc_cfg_type   cfg_q;
    adcc_pkg::adcc_cfg_type   cfg_d;
    adcc_pkg::adcc_route_type route_q;
    adcc_pkg::adcc_route_type route_d;
    logic [15:0]              snap_q;
    logic [15:0]              snap_d;
    logic                     new_q;
    logic                     new_d;
    logic                     cfg_wr;
    logic                     start_req;

    assign cfg_wr    = tgl_edge & (shadow_q.write_key == adcc_pkg::WRITE_KEY);
    assign start_req = cfg_wr & shadow_q.start & shadow_q.single;

    always_comb begin
        cfg_d  = cfg_q;
        snap_d = snap_q;
        new_d  = new_q;
        if (cfg_wr) begin
            cfg_d       = shadow_q; // RULE_12
            cfg_d.start = 1'b0;
        end
        if (tgl_edge) begin
            new_d = 1'b0;
        end
        // New result wins over a read clear
        if (pop) begin
            snap_d = mem_q[rd_q]; // RULE_11
            new_d  = 1'b1;
        end
        route_d = sel_route(cfg_d.input_select_field); // RULE_13 RULE_15
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cfg_q   <= adcc_pkg::CFG_RST;
            route_q <= '0;
            snap_q  <= '0;
            new_q   <= 1'b0;
        end else if (i_clk_en) begin
            cfg_q   <= cfg_d;
            route_q <= route_d;
            snap_q  <= snap_d;
            new_q   <= new_d;
        end
    end

    // Conversion sequencer
    adcc_pkg::adcc_state_type state_q;
    adcc_pkg::adcc_state_type state_d;
    adcc_tmr_type             timer_q;
    adcc_tmr_type             timer_d;
    logic                     end_q;
    logic                     end_d;

    always_comb begin
        state_d = state_q;
        timer_d = timer_q;
        end_d   = 1'b0;
        case (state_q)
            adcc_pkg::ADCC_PD: begin
                if (start_req || !cfg_q.single) begin
                    state_d = adcc_pkg::ADCC_CONV; // RULE_07
                    // Start word's own rate applies at once
                    timer_d = conv_last(cfg_d.rate);
                end
            end
            adcc_pkg::ADCC_CONV: begin
                if (timer_q == '0) begin
                    end_d = 1'b1;
                    if (cfg_q.single) begin
                        state_d = adcc_pkg::ADCC_PD; // RULE_08
                    end else begin
                        timer_d = conv_last(cfg_q.rate); // RULE_09 RULE_10
                    end
                end else begin
                    timer_d = timer_q - 1'b1;
                end
            end
            default: begin
                state_d = adcc_pkg::ADCC_PD;
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_q <= adcc_pkg::ADCC_PD;
            timer_q <= '0;
            end_q   <= 1'b0;
        end else if (i_clk_en) begin
            state_q <= state_d;
            timer_q <= timer_d;
            end_q   <= end_d;
        end
    end

    assign o_conv_end   = end_q;
    assign o_power_down = (state_q == adcc_pkg::ADCC_PD);
    assign o_route      = route_q; // RULE_14
    assign o_gain       = cfg_q.gain;

    // Pin: ready flag between frames, result bits during one
    logic out_idle;

    assign out_idle    = (out_cnt_q == '0)
                       | (out_cnt_q > adcc_bit_type'(adcc_pkg::FRAME_BITS));
    assign o_dout_oe_n = i_cs_n; // RULE_05

    always_comb begin
        if (i_cs_n) begin
            o_dout = 1'b1;
        end else if (out_idle) begin
            o_dout = ~new_q; // RULE_16 RULE_02
        end else begin
            o_dout = snap_q[adcc_pkg::FRAME_BITS - int'(out_cnt_q)]; // RULE_04
        end
    end

    property p_release;
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        i_cs_n |-> o_dout_oe_n && o_dout;
    endproperty
    a_release: assert property (p_release) // RULE_05
        else $error("Pin driven with chip select high");

    property p_ready_low;
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        !i_cs_n && out_idle |-> (o_dout == !new_q) && !o_dout_oe_n;
    endproperty
    a_ready_low: assert property (p_ready_low) // RULE_16
        else $error("Idle pin does not show ready flag");

    property p_one_shot;
        @(posedge i_sys_clk) disable iff (!i_arst_n || !i_clk_en)
        state_q == adcc_pkg::ADCC_CONV && timer_q == '0 && cfg_q.single
        |=> o_conv_end && o_power_down;
    endproperty
    a_one_shot: assert property (p_one_shot) // RULE_08
        else $error("No power-down after single conversion");

    property p_rerun;
        @(posedge i_sys_clk) disable iff (!i_arst_n || !i_clk_en)
        state_q == adcc_pkg::ADCC_CONV && timer_q == '0 && !cfg_q.single
        |=> !o_power_down && timer_q == conv_last($past(cfg_q.rate));
    endproperty
    a_rerun: assert property (p_rerun) // RULE_09
        else $error("Continuous mode did not restart at rate");

    property p_start;
        @(posedge i_sys_clk) disable iff (!i_arst_n || !i_clk_en)
        o_power_down && start_req
        |=> !o_power_down && timer_q == conv_last(cfg_q.rate);
    endproperty
    a_start: assert property (p_start) // RULE_07
        else $error("Requested conversion did not start");

    property p_timeout;
        @(posedge i_sys_clk) disable iff (!i_arst_n || !i_clk_en)
        !sck_s_q && to_cnt_q == adcc_to_type'(TIMEOUT_CYC - 1)
        |=> timeout_q;
    endproperty
    a_timeout: assert property (p_timeout) // RULE_06
        else $error("Serial clock timeout missed");

    property p_latest;
        @(posedge i_sys_clk) disable iff (!i_arst_n || !i_clk_en)
        pop |=> new_q && snap_q == $past(mem_q[rd_q]);
    endproperty
    a_latest: assert property (p_latest) // RULE_11
        else $error("Snapshot is not the newest result");

    property p_select;
        @(posedge i_sys_clk) disable iff (!i_arst_n || !i_clk_en)
        cfg_wr |=> cfg_q.input_select_field == $past(shadow_q[14:12]);
    endproperty
    a_select: assert property (p_select) // RULE_12
        else $error("Input select field not taken");

    property p_ground;
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        cfg_q.input_select_field[2] |->
        o_route.neg == adcc_pkg::ADCC_NEG_GND
        && o_route.pos == cfg_q.input_select_field[1:0];
    endproperty
    a_ground: assert property (p_ground) // RULE_14
        else $error("Single-ended route not to ground");

    property p_pair;
        @(posedge i_sys_clk) disable iff (!i_arst_n)
        cfg_q.input_select_field == 3'h0 |->
        o_route.pos == 2'h0 && o_route.neg == adcc_pkg::ADCC_NEG_IN1;
    endproperty
    a_pair: assert property (p_pair) // RULE_15
        else $error("First pair routed wrongly");
endmodule
`default_nettype wire

// ===== adcc_host.sv
// Behavioural serial host: selects, clocks and shifts 16-bit words.
// Assumes the resolved device pin is fed back on i_pin.
`timescale 1ns/1ps
`default_nettype none
module adcc_host #(
    parameter int HALF = 32
) (
    input  wire logic i_pin,
    output var logic  o_sclk,
    output var logic  o_cs_n,
    output var logic  o_din
);
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_din  = 1'b0;
    end

    // Setup and hold around the select change
    task automatic select(input logic on);
        #(4*HALF+7);
        o_cs_n <= ~on;
        #(4*HALF);
    endtask

    // Data moves at the rising edge, pin captured at the falling edge
    task automatic shift(input int n, input logic [15:0] wr,
                         output logic [15:0] rd);
        rd = 16'h0000;
        for (int i = 0; i < n; i++) begin
            o_sclk <= 1'b1;
            o_din  <= wr[15-(i%16)];
            #(HALF);
            rd = {rd[14:0], i_pin};
            o_sclk <= 1'b0;
            #(HALF);
        end
        o_din <= ~o_din;
    endtask

    // Clock held low on purpose
    task automatic hold_low(input int ns);
        #(ns);
    endtask
endmodule
`default_nettype wire

// ===== adcc_ctrl_test.sv
// Testbench for the converter control: serial host, result feed and
// conversion timing. Assumes adcc_host and adcc_pkg are compiled first.
`timescale 1ns/1ps
`default_nettype none
module adcc_ctrl_test;
    localparam int CONV_HZ = 200000;
    localparam int TMO     = 200;
    logic                     clk;
    logic                     arst_n;
    logic                     clk_en;
    logic                     res_valid;
    logic [15:0]              res_data;
    logic                     dout;
    logic                     dout_oe_n;
    logic                     conv_end;
    logic                     pd;
    logic                     res_ready;
    logic [2:0]               gain;
    adcc_pkg::adcc_route_type route;
    wire logic                sclk;
    wire logic                cs_n;
    wire logic                din;
    wire logic                pin;
    int                       fail_count;
    int                       compares;

    // Released pin falls to its pull-down
    assign pin = dout_oe_n ? 1'b0 : dout;

    adcc_ctrl #(
        .CONV_CLK_HZ (CONV_HZ),
        .TIMEOUT_CYC (TMO),
        .DEPTH       (2)
    ) dut (
        .i_sys_clk    (clk),
        .i_arst_n     (arst_n),
        .i_clk_en     (clk_en),
        .i_sclk       (sclk),
        .i_cs_n       (cs_n),
        .i_din        (din),
        .o_dout       (dout),
        .o_dout_oe_n  (dout_oe_n),
        .o_conv_end   (conv_end),
        .o_power_down (pd),
        .o_route      (route),
        .o_gain       (gain),
        .i_res_valid  (res_valid),
        .i_res_data   (res_data),
        .o_res_ready  (res_ready)
    );

    adcc_host host (
        .i_pin  (pin),
        .o_sclk (sclk),
        .o_cs_n (cs_n),
        .o_din  (din)
    );

    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp, got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    function automatic logic [15:0] cfg(logic st, logic [2:0] sel,
            logic [2:0] g, logic sg, logic [2:0] r);
        return {st, sel, g, sg, r, 2'h0, adcc_pkg::WRITE_KEY, 1'b0};
    endfunction

    task automatic wr_cfg(input logic [15:0] w);
        logic [15:0] rd;
        host.select(1'b1);
        host.shift(16, w, rd);
        host.select(1'b0);
        cyc(5);
    endtask

    // Sys cycles up to and including the next conversion-end pulse
    task automatic wait_conv(output int n);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (conv_end !== 1'b1 && n < 30000);
        if (conv_end !== 1'b1) begin
            fail_count++;
            $display("MISMATCH conv_end expected 1 seen %b", conv_end);
        end
    endtask

    task automatic push(input logic [15:0] w, input logic hold);
        logic r;
        int   n;
        res_valid <= 1'b1;
        res_data  <= w;
        n = 0;
        do begin
            @(negedge clk);
            r = res_ready;
            @(posedge clk);
            n++;
        end while (r !== 1'b1 && n < 50);
        if (r !== 1'b1) begin
            fail_count++;
            $display("MISMATCH res_ready expected 1 seen %b", r);
        end
        if (!hold) res_valid <= 1'b0;
    endtask

    task automatic t_reset();
        check("power_down", 16'h1, 16'(pd));
        check("gain", 16'h2, 16'(gain));
        check("route", 16'h0, 16'(route));
        check("oe_n", 16'h1, 16'(dout_oe_n));
        check("dout", 16'h1, 16'(dout));
    endtask

    task automatic t_select();
        logic [2:0]            s;
        logic [1:0]            pos;
        adcc_pkg::adcc_neg_type neg;
        for (int i = 0; i < 8; i++) begin
            s = 3'(i);
            wr_cfg(cfg(1'b0, s, s, 1'b1, 3'h4));
            pos = s[2] ? s[1:0] : (s == 3'h0 ? 2'h0 : s[1:0] - 2'h1);
            neg = s[2] ? adcc_pkg::ADCC_NEG_GND :
                  (s == 3'h0 ? adcc_pkg::ADCC_NEG_IN1 : adcc_pkg::ADCC_NEG_IN3);
            check("route", 16'({pos, neg}), 16'(route));
            check("gain", 16'(s), 16'(gain));
        end
        wr_cfg(16'h0954);
        check("route bad key", 16'({2'h3, adcc_pkg::ADCC_NEG_GND}),
              16'(route));
    endtask

    task automatic t_single();
        int n;
        wr_cfg(cfg(1'b1, 3'h0, 3'h2, 1'b1, 3'h7));
        check("converting", 16'h0, 16'(pd));
        // Clock enable low must hold the conversion still
        clk_en <= 1'b0;
        n = 0;
        repeat (300) begin
            @(negedge clk);
            if (conv_end === 1'b1) n++;
        end
        @(posedge clk);
        clk_en <= 1'b1;
        check("frozen", 16'h0, 16'(n));
        check("frozen pd", 16'h0, 16'(pd));
        wait_conv(n);
        check("single done", 16'h1, 16'(n <= CONV_HZ / 860));
        cyc(2);
        check("auto power down", 16'h1, 16'(pd));
        n = 0;
        repeat (600) begin
            @(negedge clk);
            if (conv_end === 1'b1) n++;
        end
        check("extra conversions", 16'h0, 16'(n));
    endtask

    task automatic t_cont();
        int n;
        for (int r = 7; r > 5; r--) begin
            wr_cfg(cfg(1'b0, 3'h0, 3'h2, 1'b0, 3'(r)));
            wait_conv(n);
            repeat (2) begin
                wait_conv(n);
                check("period", 16'(CONV_HZ / adcc_pkg::SPS_TABLE[r]),
                      16'(n));
                check("running", 16'h0, 16'(pd));
            end
        end
        wr_cfg(cfg(1'b0, 3'h0, 3'h2, 1'b1, 3'h4));
        wait_conv(n);
        cyc(2);
        check("stopped", 16'h1, 16'(pd));
    endtask

    task automatic t_read();
        logic [15:0] rd;
        push(16'ha5c3, 1'b1);
        push(16'h3c5a, 1'b0);
        cyc(4);
        host.select(1'b1);
        check("ready shown", 16'h0, 16'(pin));
        check("oe_n low", 16'h0, 16'(dout_oe_n));
        host.shift(16, 16'h0000, rd);
        check("read", 16'h3c5a, rd);
        host.select(1'b0);
        cyc(5);
        check("oe_n high", 16'h1, 16'(dout_oe_n));
        host.select(1'b1);
        check("ready cleared", 16'h1, 16'(pin));
        host.select(1'b0);
    endtask

    task automatic t_full();
        logic [15:0] rd;
        host.select(1'b1);
        cyc(4);
        push(16'h1234, 1'b1);
        push(16'hbeef, 1'b0);
        @(negedge clk);
        check("buffer full", 16'h0, 16'(res_ready));
        host.select(1'b0);
        cyc(6);
        check("buffer drained", 16'h1, 16'(res_ready));
        host.select(1'b1);
        host.shift(16, 16'h0000, rd);
        host.select(1'b0);
        check("latest", 16'hbeef, rd);
    endtask

    task automatic t_timeout();
        logic [15:0] rd;
        host.select(1'b1);
        host.shift(8, 16'hffff, rd);
        host.hold_low(TMO * 40 + 2000);
        host.shift(16, cfg(1'b0, 3'h5, 3'h2, 1'b1, 3'h4), rd);
        host.select(1'b0);
        cyc(5);
        check("read after idle", 16'hbeef, rd);
        check("route after idle", 16'({2'h1, adcc_pkg::ADCC_NEG_GND}),
              16'(route));
    endtask

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        #2000000;
        fail_count++;
        finish_test();
    end

    initial begin
        arst_n     = 1'b0;
        clk_en     = 1'b1;
        res_valid  = 1'b0;
        res_data   = 16'h0000;
        fail_count = 0;
        compares   = 0;
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        cyc(4);
        t_reset();
        t_select();
        t_single();
        t_cont();
        t_read();
        t_full();
        t_timeout();
        finish_test();
    end
endmodule
`default_nettype wire
